// ### common/bank_ctl_pkg.sv
// Constants for the bank write-termination and precharge block.
// Assumes a 100 MHz command clock; all timing figures are in ns.
package bank_ctl_pkg;
  localparam int unsigned clk_period_ns = 10;
  localparam int unsigned num_banks = 4;
  localparam int unsigned dq_width = 16;
  localparam int unsigned num_lanes = dq_width / 8;
  localparam int unsigned col_width = 10;
  localparam int unsigned row_width = 14;
  // Timing figures (plain defaults) and derived cycle counts
  localparam int unsigned t_wr_ns = 15;
  localparam int unsigned t_ras_ns = 42;
  localparam int unsigned t_rp_ns = 18;
  localparam int unsigned t_wtr_ns = 10;
  localparam int unsigned wr_cycles = (t_wr_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned ras_cycles = (t_ras_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned rp_cycles = (t_rp_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned wtr_cycles = (t_wtr_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned cnt_width = 5;
  localparam logic [cnt_width-1:0] wr_cnt = cnt_width'(wr_cycles);
  localparam logic [cnt_width-1:0] ras_cnt = cnt_width'(ras_cycles);
  localparam logic [cnt_width-1:0] rp_cnt = cnt_width'(rp_cycles);
  localparam logic [cnt_width-1:0] wtr_cnt = cnt_width'(wtr_cycles);
  // Field positions
  localparam int unsigned ap_bit = 10;
  // Burst length codes
  localparam logic [1:0] bl_2 = 2'h0;
  localparam logic [1:0] bl_4 = 2'h1;
  localparam logic [1:0] bl_8 = 2'h2;
  localparam logic [1:0] bl_16 = 2'h3;
  // Command and bank state encodings
  typedef enum logic [2:0] {cmd_nop, cmd_act, cmd_rd, cmd_wr, cmd_pre} cmd_t;
  typedef enum logic [1:0] {bank_idle, bank_active, bank_access, bank_prech} bank_st_t;
endpackage

// ### rtl/bank_timer.sv
// One bank's state and its recovery, row-active and precharge counters.
// Assumes commands arrive decoded and one per clock from the top.
`timescale 1ns/1ns
module bank_timer
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic act_i,
  input wire logic access_i,
  input wire logic auto_pre_i,
  input wire logic burst_done_i,
  input wire logic pre_i,
  output logic [1:0] state_o,
  output logic pre_start_o
);
  // ****************************************
  // Bank state
  // ****************************************
  bank_ctl_pkg::bank_st_t st_ff;
  bank_ctl_pkg::bank_st_t nxt_st;
  logic [bank_ctl_pkg::cnt_width-1:0] ras_ff;
  logic [bank_ctl_pkg::cnt_width-1:0] wr_ff;
  logic [bank_ctl_pkg::cnt_width-1:0] rp_ff;
  logic ap_ff;
  logic done_seen_ff;
  wire ras_met = (ras_ff == '0);
  wire wr_met = done_seen_ff && (wr_ff == '0);
  // Auto precharge fires at the first cycle tRAS and write recovery both allow
  wire ap_fire = (st_ff == bank_ctl_pkg::bank_access) && ap_ff && ras_met && wr_met;
  // Explicit precharge on a closed or closing bank is a no-op
  wire pre_take = pre_i && ((st_ff == bank_ctl_pkg::bank_active) ||
    (st_ff == bank_ctl_pkg::bank_access && !ap_ff));
  wire rp_done = (st_ff == bank_ctl_pkg::bank_prech) && (rp_ff <= 5'h1);

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      bank_ctl_pkg::bank_idle:
        if (act_i)
          nxt_st = bank_ctl_pkg::bank_active;
      bank_ctl_pkg::bank_active:
        if (pre_take)
          nxt_st = bank_ctl_pkg::bank_prech;
        else if (access_i)
          nxt_st = bank_ctl_pkg::bank_access;
      bank_ctl_pkg::bank_access:
        if (ap_fire || pre_take)
          nxt_st = bank_ctl_pkg::bank_prech;
        else if (done_seen_ff && !ap_ff && wr_ff == '0)
          nxt_st = bank_ctl_pkg::bank_active;
      bank_ctl_pkg::bank_prech:
        if (rp_done)
          nxt_st = bank_ctl_pkg::bank_idle;
      default:
        nxt_st = bank_ctl_pkg::bank_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= bank_ctl_pkg::bank_idle;
      ras_ff <= '0;
      wr_ff <= '0;
      rp_ff <= '0;
      ap_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      pre_start_o <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      pre_start_o <= (nxt_st == bank_ctl_pkg::bank_prech) && (st_ff != bank_ctl_pkg::bank_prech);
      if (act_i && st_ff == bank_ctl_pkg::bank_idle)
        ras_ff <= bank_ctl_pkg::ras_cnt - 5'h1;
      else if (!ras_met)
        ras_ff <= ras_ff - 5'h1;
      // Auto precharge latched per access only
      if (access_i)
        ap_ff <= auto_pre_i;
      else if (nxt_st != bank_ctl_pkg::bank_access)
        ap_ff <= 1'b0;
      // Write recovery timed from the edge after the final pair
      if (access_i)
        done_seen_ff <= 1'b0;
      else if (burst_done_i)
        done_seen_ff <= 1'b1;
      if (burst_done_i)
        wr_ff <= bank_ctl_pkg::wr_cnt - 5'h1;
      else if (wr_ff != '0)
        wr_ff <= wr_ff - 5'h1;
      if (nxt_st == bank_ctl_pkg::bank_prech && st_ff != bank_ctl_pkg::bank_prech)
        rp_ff <= bank_ctl_pkg::rp_cnt;
      else if (rp_ff != '0)
        rp_ff <= rp_ff - 5'h1;
    end
  end

  assign state_o = st_ff;

  chk_ap_waits_ras: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == bank_ctl_pkg::bank_access && nxt_st == bank_ctl_pkg::bank_prech && ap_ff) |-> ras_met)
    else $error("auto precharge before row active minimum");
  chk_prech_ends: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(st_ff == bank_ctl_pkg::bank_prech) |-> ##[1:8] st_ff == bank_ctl_pkg::bank_idle)
    else $error("precharge never completes");
endmodule

// ### rtl/write_truncate_bank_precharge.sv
// Bank write-termination and precharge logic of a four-bank DDR memory.
// Assumes command decode synchronous to mclk; strobe edges arrive as
// per-lane qualified samples (rise/fall) already aligned to mclk.
`timescale 1ns/1ns
module write_truncate_bank_precharge
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] cmd,
  input wire logic [1:0] bank_addr,
  input wire logic [13:0] addr,
  input wire logic [1:0] burst_len,
  input wire logic [15:0] dq_rise,
  input wire logic [15:0] dq_fall,
  input wire logic lower_byte_strobe,
  input wire logic upper_byte_strobe,
  input wire logic lower_byte_mask_rise,
  input wire logic lower_byte_mask_fall,
  input wire logic upper_byte_mask_rise,
  input wire logic upper_byte_mask_fall,
  output logic arr_we,
  output logic [1:0] arr_bank,
  output logic [9:0] arr_col,
  output logic [31:0] arr_data,
  output logic [3:0] arr_byte_en,
  output logic [7:0] bank_state,
  output logic wtr_busy
);
  // ****************************************
  // Command decode
  // ****************************************
  wire is_act = (cmd == bank_ctl_pkg::cmd_act);
  wire is_rd = (cmd == bank_ctl_pkg::cmd_rd);
  wire is_wr = (cmd == bank_ctl_pkg::cmd_wr);
  wire is_pre = (cmd == bank_ctl_pkg::cmd_pre);
  wire a10 = addr[bank_ctl_pkg::ap_bit];
  wire [3:0] bank_sel = 4'h1 << bank_addr;
  // Burst pairs less one: BL/2 - 1
  wire [3:0] pairs_m1 = (burst_len == bank_ctl_pkg::bl_2) ? 4'h0 :
    (burst_len == bank_ctl_pkg::bl_4) ? 4'h1 :
    (burst_len == bank_ctl_pkg::bl_8) ? 4'h3 : 4'h7;

  // ****************************************
  // Write burst tracking
  // ****************************************
  logic wr_pend_ff;
  logic wr_run_ff;
  logic [3:0] pair_ff;
  logic [3:0] last_ff;
  logic [1:0] wbank_ff;
  logic [9:0] wcol_ff;
  logic rd_run_ff;
  logic [3:0] rpair_ff;
  logic [1:0] rbank_ff;
  logic [3:0] wr_done;
  logic [3:0] rd_done;
  logic [bank_ctl_pkg::cnt_width-1:0] wtr_ff;
  // A precharge to the writing bank, or any read or write, cuts the burst short
  wire trunc_pre = is_pre && (a10 || bank_addr == wbank_ff);
  wire cut = (wr_run_ff || wr_pend_ff) && (is_rd || trunc_pre || is_wr);
  wire pair_take = wr_run_ff && lower_byte_strobe && upper_byte_strobe && !cut;
  wire wr_last = pair_take && (pair_ff == last_ff);
  // Interleaved order within the pair group, fixed for every burst
  wire [9:0] col_now = {wcol_ff[9:4], wcol_ff[3:0] ^ {pair_ff[2:0], 1'b0}};
  // Live per-bank state, one cycle ahead of the registered bank_state port
  wire [7:0] st_all;
  logic [3:0] pre_start;
  logic [3:0] lane_keep;

  // Mask per byte lane and edge; rise element in low half, fall in high
  assign lane_keep = {~upper_byte_mask_fall, ~lower_byte_mask_fall,
    ~upper_byte_mask_rise, ~lower_byte_mask_rise};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_run_ff <= 1'b0;
      pair_ff <= 4'h0;
      last_ff <= 4'h0;
      wbank_ff <= 2'h0;
      wcol_ff <= 10'h0;
    end
    else
    begin
      // First pair comes two clocks after the command
      wr_pend_ff <= 1'b0;
      if (is_wr)
      begin
        wr_pend_ff <= 1'b1;
        wbank_ff <= bank_addr;
        wcol_ff <= addr[9:0];
        last_ff <= pairs_m1;
      end
      if (wr_pend_ff && !cut)
      begin
        wr_run_ff <= 1'b1;
        pair_ff <= 4'h0;
      end
      else if (cut || wr_last)
        wr_run_ff <= 1'b0;
      else if (pair_take)
        pair_ff <= pair_ff + 4'h1;
    end
  end

  // ****************************************
  // Array write port
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arr_we <= 1'b0;
      arr_bank <= 2'h0;
      arr_col <= 10'h0;
      arr_data <= 32'h0;
      arr_byte_en <= 4'h0;
    end
    else
    begin
      arr_we <= pair_take && (lane_keep != 4'h0);
      arr_bank <= wbank_ff;
      arr_col <= col_now;
      arr_data <= {dq_fall, dq_rise};
      arr_byte_en <= lane_keep;
    end
  end

  // ****************************************
  // Read burst end (for auto precharge)
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_run_ff <= 1'b0;
      rpair_ff <= 4'h0;
      rbank_ff <= 2'h0;
    end
    else if (is_rd)
    begin
      rd_run_ff <= 1'b1;
      rpair_ff <= pairs_m1;
      rbank_ff <= bank_addr;
    end
    else if (rd_run_ff && (rpair_ff == 4'h0 || is_wr || is_pre))
      rd_run_ff <= 1'b0;
    else if (rd_run_ff)
      rpair_ff <= rpair_ff - 4'h1;
  end

  // Read precharge may start BL/2 clocks after the command
  assign rd_done = (rd_run_ff && rpair_ff == 4'h0) ? (4'h1 << rbank_ff) : 4'h0;
  // Recovery counts from the edge after the final pair or the cut
  assign wr_done = ((wr_last || (cut && wr_run_ff)) ? (4'h1 << wbank_ff) : 4'h0);

  // ****************************************
  // Write-to-read delay
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wtr_ff <= '0;
    else if (wr_last)
      wtr_ff <= bank_ctl_pkg::wtr_cnt;
    else if (wtr_ff != '0)
      wtr_ff <= wtr_ff - 5'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wtr_busy <= 1'b0;
    else
      wtr_busy <= wr_last || (wtr_ff > 5'h1);
  end

  // ****************************************
  // Per-bank state
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      wire [1:0] st;
      bank_timer u_bank
      (
        .mclk(mclk),
        .rst_n(rst_n),
        .act_i(is_act && bank_sel[gi]),
        .access_i((is_rd || is_wr) && bank_sel[gi]),
        .auto_pre_i(a10),
        .burst_done_i(wr_done[gi] || rd_done[gi]),
        .pre_i(is_pre && (a10 || bank_sel[gi])),
        .state_o(st),
        .pre_start_o(pre_start[gi])
      );
      assign st_all[2*gi +: 2] = st;
      chk_bank_pre_taken: assert property (@(posedge mclk) disable iff (!rst_n)
        (is_pre && (a10 || bank_sel[gi]) && st == bank_ctl_pkg::bank_active) |=> pre_start[gi])
        else $error("precharge to an open bank ignored");
    end
  endgenerate

  // One register for the whole field keeps a single writer per variable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bank_state <= 8'h0;
    else
      bank_state <= st_all;
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_cut_no_store: assert property (@(posedge mclk) disable iff (!rst_n)
    cut |=> !arr_we)
    else $error("data stored after truncation");
  chk_mask_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    (pair_take && lane_keep == 4'h0) |=> !arr_we)
    else $error("masked pair written");
  chk_lane_stored: assert property (@(posedge mclk) disable iff (!rst_n)
    (pair_take && lane_keep != 4'h0) |=> arr_we)
    else $error("unmasked pair not written");
  chk_wtr_after_last: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_last |=> wtr_busy)
    else $error("write to read delay not started");
  chk_wtr_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (wtr_ff == '0 && !wr_last) |=> !wtr_busy)
    else $error("write to read delay overstayed");
  // The live state is used, since the port lags and would miss a bank just opened
  chk_pre_on_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (is_pre && !a10 && (st_all[2*bank_addr +: 2] == 2'h0 || st_all[2*bank_addr +: 2] == 2'h3))
    |=> !pre_start[$past(bank_addr)])
    else $error("precharge on idle bank acted");
  chk_pair_count: assert property (@(posedge mclk) disable iff (!rst_n)
    pair_take |-> pair_ff <= last_ff)
    else $error("burst overran its length");

  // ****************************************
  // Multi-step write and read checks
  // ****************************************
  // A write on a quiet bus, then one cycle of preamble with no cut
  sequence s_wr_open;
    is_wr && !wr_run_ff && !wr_pend_ff;
  endsequence
  sequence s_no_cut;
    !cut;
  endsequence
  sequence s_wr_cut;
    wr_run_ff && cut;
  endsequence

  chk_run_opens: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_open ##1 s_no_cut |=> wr_run_ff && pair_ff == 4'h0)
    else $error("write burst did not open after its preamble");
  chk_burst_closes: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_last |=> !wr_run_ff && !pair_take)
    else $error("write burst ran past its last pair");
  chk_cut_closes: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_cut |=> !wr_run_ff)
    else $error("write burst kept running after a cut");
  chk_pair_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    pair_take |=> arr_col == $past(col_now) && arr_byte_en == $past(lane_keep))
    else $error("stored pair lost its column or lanes");
  // A read restarted on its last cycle legally raises the end again
  chk_rd_end_once: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_done != 4'h0 && !is_rd) |=> rd_done == 4'h0)
    else $error("read burst end seen twice");
endmodule

// ### dv/ctl_model.sv
// Controller model: commands, write pairs, strobes and masks.
// Assumes one step call per clock; all signals change at the falling edge.
`timescale 1ns/1ns
module ctl_model
(
  input wire logic mclk,
  output logic [2:0] cmd,
  output logic [1:0] bank_addr,
  output logic [13:0] addr,
  output logic [1:0] burst_len,
  output logic [15:0] dq_rise,
  output logic [15:0] dq_fall,
  output logic lower_byte_strobe,
  output logic upper_byte_strobe,
  output logic [3:0] mask
);
  initial
  begin
    {cmd, bank_addr, addr, burst_len, dq_rise, dq_fall, mask} = '0;
    lower_byte_strobe = 1'b0;
    upper_byte_strobe = 1'b0;
  end
  // ******************************************
  // One cycle of controller traffic
  // ******************************************
  // Callers keep tRP, tWR and tWTR gaps to the same bank
  task automatic step(input logic [2:0] c, input logic [1:0] b, input logic [13:0] a,
    input logic s, input logic [15:0] r, input logic [3:0] m);
  begin
    @(negedge mclk);
    cmd = c;
    bank_addr = b;
    addr = a;
    // Strobe low outside pairs; first pair two clocks after the write
    // Cut slots are still strobed so the mask registers
    lower_byte_strobe = s;
    upper_byte_strobe = s;
    // Released lines flip so a stale value never looks valid
    dq_rise = s ? r : ~dq_rise;
    dq_fall = s ? ~r : ~dq_fall;
    mask = s ? m : ~mask;
  end
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the bank write-termination and precharge block.
// Assumes ctl_model drives every design input except mclk and rst_n.
`timescale 1ns/1ns
module testbench;
  logic mclk;
  logic rst_n;
  logic [2:0] cmd;
  logic [1:0] bank_addr;
  logic [13:0] addr;
  logic [1:0] burst_len;
  logic [15:0] dq_rise;
  logic [15:0] dq_fall;
  logic lower_byte_strobe;
  logic upper_byte_strobe;
  logic [3:0] mask;
  logic arr_we;
  logic [1:0] arr_bank;
  logic [9:0] arr_col;
  logic [31:0] arr_data;
  logic [3:0] arr_byte_en;
  logic [7:0] bank_state;
  logic wtr_busy;
  logic [47:0] wq[$];
  int wtr_hi;
  int failures;
  int total_checks;

  ctl_model u_ctl_model (.mclk(mclk), .cmd(cmd), .bank_addr(bank_addr), .addr(addr),
    .burst_len(burst_len), .dq_rise(dq_rise), .dq_fall(dq_fall), .lower_byte_strobe(lower_byte_strobe),
    .upper_byte_strobe(upper_byte_strobe), .mask(mask));
  write_truncate_bank_precharge u_write_truncate_bank_precharge (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
    .bank_addr(bank_addr), .addr(addr), .burst_len(burst_len), .dq_rise(dq_rise), .dq_fall(dq_fall),
    .lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe),
    .lower_byte_mask_rise(mask[0]), .lower_byte_mask_fall(mask[2]), .upper_byte_mask_rise(mask[1]),
    .upper_byte_mask_fall(mask[3]), .arr_we(arr_we), .arr_bank(arr_bank), .arr_col(arr_col),
    .arr_data(arr_data), .arr_byte_en(arr_byte_en), .bank_state(bank_state), .wtr_busy(wtr_busy));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Array writes are queued so checks do not hang on exact latency
  always @(posedge mclk)
  begin
    if (arr_we === 1'b1)
      wq.push_back({arr_bank, arr_col, arr_byte_en, arr_data});
    if (wtr_busy === 1'b1)
      wtr_hi++;
  end

  // ******************************************
  // Shared helpers
  // ******************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic results();
  begin
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [13:0] a);
    u_ctl_model.step(c, b, a, 1'b0, 16'h0, 4'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) op(bank_ctl_pkg::cmd_nop, 2'h0, 14'h0);
  endtask

  task automatic pair(input logic [1:0] b, input logic [15:0] r, input logic [3:0] m);
    u_ctl_model.step(bank_ctl_pkg::cmd_nop, b, 14'h0, 1'b1, r, m);
  endtask

  // Bounded wait on one bank's state field; n is the cycles taken
  task automatic wait_bank(input int b, input logic [1:0] v, input int lim, output int n);
  begin
    n = 0;
    while (bank_state[2*b +: 2] !== v)
    begin
      idle(1);
      n++;
      if (n > lim)
      begin
        failures++;
        $display("mismatch at %0t: bank %0d stuck", $time, b);
        results();
      end
    end
  end
  endtask

  // ******************************************
  // Scenarios
  // ******************************************
  task automatic t_bursts();
    int n;
    int p;
    logic [15:0] r;
  begin
    op(bank_ctl_pkg::cmd_act, 2'h1, 14'h0);
    wait_bank(1, 2'h1, 4, n);
    for (int i = 0; i < 4; i++)
    begin
      u_ctl_model.burst_len = 2'(i);
      p = 1 << (i + 1);
      p = p / 2;
      wq.delete();
      wtr_hi = 0;
      op(bank_ctl_pkg::cmd_wr, 2'h1, 14'h020);
      // Strobe stays low for one preamble cycle before the first pair
      idle(1);
      // One pair past the burst end must be dropped
      for (int j = 0; j <= p; j++)
        pair(2'h1, 16'h0a00 + 16'(16 * i + j), 4'(j));
      idle(4);
      check(48'(wq.size()), 48'(p));
      check(48'(wtr_hi), 48'(bank_ctl_pkg::wtr_cycles));
      foreach (wq[j])
      begin
        r = 16'h0a00 + 16'(16 * i + j);
        check(wq[j], {2'h1, 10'h020 ^ 10'(2 * j), ~4'(j), ~r, r});
      end
    end
    op(bank_ctl_pkg::cmd_pre, 2'h1, 14'h0);
    wait_bank(1, 2'h0, 8, n);
  end
  endtask

  task automatic t_trunc();
    int n;
  begin
    op(bank_ctl_pkg::cmd_act, 2'h2, 14'h0);
    idle(bank_ctl_pkg::ras_cycles);
    u_ctl_model.burst_len = bank_ctl_pkg::bl_8;
    wq.delete();
    op(bank_ctl_pkg::cmd_wr, 2'h2, 14'h040);
    idle(1);
    pair(2'h2, 16'h1111, 4'h0);
    pair(2'h2, 16'h2222, 4'h0);
    u_ctl_model.step(bank_ctl_pkg::cmd_pre, 2'h2, 14'h0, 1'b1, 16'h3333, 4'hf);
    // A burst of four would need no strobe or mask in this slot
    pair(2'h2, 16'h4444, 4'hf);
    wait_bank(2, 2'h3, 4, n);
    check(48'(wq.size()), 48'h2);
    check(wq[1], {2'h2, 10'h042, 4'hf, 16'hdddd, 16'h2222});
    // A second precharge lands on the bank's first idle cycle and must not restart tRP
    op(bank_ctl_pkg::cmd_pre, 2'h2, 14'h0);
    wait_bank(2, 2'h0, bank_ctl_pkg::rp_cycles + 2, n);
    op(bank_ctl_pkg::cmd_pre, 2'h2, 14'h0);
    idle(4);
    check(48'(bank_state), 48'h0);
    // A read cuts a running write just as a precharge does
    op(bank_ctl_pkg::cmd_act, 2'h2, 14'h0);
    wq.delete();
    op(bank_ctl_pkg::cmd_wr, 2'h2, 14'h080);
    idle(1);
    pair(2'h2, 16'h7777, 4'h0);
    u_ctl_model.step(bank_ctl_pkg::cmd_rd, 2'h2, 14'h0, 1'b1, 16'h8888, 4'hf);
    idle(bank_ctl_pkg::ras_cycles + 8);
    check(48'(wq.size()), 48'h1);
    check(wq[0], {2'h2, 10'h080, 4'hf, 16'h8888, 16'h7777});
    check(48'(bank_state), 48'h10);
    op(bank_ctl_pkg::cmd_pre, 2'h2, 14'h0);
    wait_bank(2, 2'h0, 8, n);
  end
  endtask

  task automatic t_all();
    int n;
  begin
    for (int k = 0; k < 2; k++)
    begin
      op(bank_ctl_pkg::cmd_act, 2'h0, 14'h0);
      op(bank_ctl_pkg::cmd_act, 2'h3, 14'h0);
      idle(bank_ctl_pkg::ras_cycles);
      // A10 high closes every bank; bank address ignored
      op(bank_ctl_pkg::cmd_pre, k ? 2'h3 : 2'h1, k ? 14'h0 : 14'h400);
      wait_bank(3, 2'h3, 4, n);
      check(48'(bank_state), k ? 48'hc1 : 48'hc3);
      wait_bank(3, 2'h0, 8, n);
    end
    op(bank_ctl_pkg::cmd_pre, 2'h0, 14'h0);
    wait_bank(0, 2'h0, 8, n);
  end
  endtask

  task automatic t_auto();
    int n;
  begin
    u_ctl_model.burst_len = bank_ctl_pkg::bl_2;
    op(bank_ctl_pkg::cmd_act, 2'h1, 14'h0);
    op(bank_ctl_pkg::cmd_wr, 2'h1, 14'h400);
    idle(1);
    pair(2'h1, 16'h5a5a, 4'h0);
    wait_bank(1, 2'h3, 12, n);
    check(48'(n + 1 >= bank_ctl_pkg::ras_cycles), 48'h1);
    wait_bank(1, 2'h0, 8, n);
    op(bank_ctl_pkg::cmd_act, 2'h1, 14'h0);
    idle(bank_ctl_pkg::ras_cycles);
    op(bank_ctl_pkg::cmd_wr, 2'h1, 14'h0);
    idle(1);
    pair(2'h1, 16'h1234, 4'h0);
    idle(10);
    check(48'(bank_state[3:2]), 48'h1);
    op(bank_ctl_pkg::cmd_wr, 2'h1, 14'h400);
    idle(1);
    pair(2'h1, 16'h4321, 4'h0);
    wait_bank(1, 2'h3, 8, n);
    check(48'(n >= bank_ctl_pkg::wr_cycles), 48'h1);
    wait_bank(1, 2'h0, 8, n);
    u_ctl_model.burst_len = bank_ctl_pkg::bl_16;
    op(bank_ctl_pkg::cmd_act, 2'h1, 14'h0);
    idle(bank_ctl_pkg::ras_cycles);
    op(bank_ctl_pkg::cmd_rd, 2'h1, 14'h400);
    wait_bank(1, 2'h3, 16, n);
    check(48'(n >= 8), 48'h1);
    wait_bank(1, 2'h0, 8, n);
  end
  endtask

  initial
  begin
    rst_n = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    check(48'({arr_we, wtr_busy, bank_state}), 48'h0);
    @(negedge mclk);
    rst_n = 1'b1;
    t_bursts();
    t_trunc();
    t_all();
    t_auto();
    results();
  end
endmodule
